// >>> tb/brsr_bank_monitor.sv
// port assertions for the reference and command register bank
`timescale 1ns/1ps
module brsr_bank_monitor
  import brsr_pkg::*;
(
  input wire logic        i_core_clk,      // clock
  input wire logic        i_reset_n,       // reset
  input wire logic [7:0]  i_addr,          // address
  input wire logic [7:0]  i_wdata,         // data
  input wire logic        i_wr,            // write
  input wire logic        i_rd,            // read
  input wire logic [7:0]  o_rdata,         // read data
  input wire logic [15:0] o_auto_baseline_correction_ref,      // reference
  input wire logic [15:0] o_force_cal_ref, // copy
  input wire logic        o_comm_err,      // error
  input wire logic        o_filter_en,     // filter
  input wire logic        o_soft_reset,    // pulse
  input wire logic        o_auto_baseline_correction_clear,    // pulse
  input wire logic        o_save_cal,      // pulse
  input wire logic        o_corr_clear     // pulse
);
  logic cmd_wr;
  logic known;
  assign cmd_wr = i_wr && i_addr == ADDR_COMMAND;
  assign known  = i_wdata inside {CMD_SOFT_RESET, CMD_AUTO_BASELINE_CORRECTION_CLEAR,
    CMD_SUPPLY_OFF, CMD_SAVE_CAL, CMD_FILTER_OFF, CMD_CORR_CLEAR,
    CMD_FILTER_ON};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  property p_cmd_rd;
    i_rd && i_addr == ADDR_COMMAND |=> o_rdata == CMD_READ_VALUE;
  endproperty
  a_cmd_rd: assert property (p_cmd_rd) else $error("command read");
  property p_scr;
    (i_wr && i_addr == ADDR_SCRATCH) ##2 (i_rd && i_addr == ADDR_SCRATCH)
      |=> o_rdata == $past(i_wdata, 3);
  endproperty
  a_scr: assert property (p_scr) else $error("scratch readback");
  property p_same;
    o_auto_baseline_correction_ref == o_force_cal_ref;
  endproperty
  a_same: assert property (p_same) else $error("reference copy");
  property p_range;
    $signed(o_auto_baseline_correction_ref) >= REF_MIN_PPM && $signed(o_auto_baseline_correction_ref) <= REF_MAX_PPM;
  endproperty
  a_range: assert property (p_range) else $error("ref range");
  property p_lo;
    i_wr && i_addr == ADDR_REF_LOW
      && $signed({o_auto_baseline_correction_ref[15:8], i_wdata}) < REF_MIN_PPM
      |=> o_auto_baseline_correction_ref == REF_MIN_PPM && o_comm_err;
  endproperty
  a_lo: assert property (p_lo) else $error("low clamp");
  property p_pls;
    cmd_wr |=> o_soft_reset == ($past(i_wdata) == CMD_SOFT_RESET)
      && o_auto_baseline_correction_clear == ($past(i_wdata) == CMD_AUTO_BASELINE_CORRECTION_CLEAR)
      && o_save_cal == ($past(i_wdata) == CMD_SAVE_CAL)
      && o_corr_clear == ($past(i_wdata) == CMD_CORR_CLEAR);
  endproperty
  a_pls: assert property (p_pls) else $error("pulse");
  property p_filt;
    cmd_wr && (i_wdata == CMD_FILTER_OFF || i_wdata == CMD_FILTER_ON)
      |=> o_filter_en == ($past(i_wdata) == CMD_FILTER_ON);
  endproperty
  a_filt: assert property (p_filt) else $error("filter");
  property p_inv;
    cmd_wr && !known |=> o_comm_err && !o_soft_reset && $stable(o_filter_en);
  endproperty
  a_inv: assert property (p_inv) else $error("bad code");
endmodule : brsr_bank_monitor
bind brsr_bank brsr_bank_monitor u_mon (.*);

// >>> tb/brsr_bank_test.sv
// self-checking bench for the reference and command register bank
`timescale 1ns/1ps
module brsr_bank_test
  import brsr_pkg::*;
;
  logic          i_core_clk = 1'b0;
  logic          i_reset_n  = 1'b0;
  brsr_bus_req_t req;
  wire  [7:0]    rdat;
  wire  [15:0]   ref_v;
  wire  [15:0]   cal_v;
  wire  [6:0]    fl;
  wire  [15:0]   flw = {9'h000, fl};
  logic [7:0]    d;
  int            mismatches = 0;
  int            n_tests    = 0;
  // code, then expected {pulses, filter, supply, error}
  logic [23:0]   rows [8] = '{{CMD_AUTO_BASELINE_CORRECTION_CLEAR, 16'h26},
    {CMD_SAVE_CAL, 16'h16}, {CMD_CORR_CLEAR, 16'h0e},
    {CMD_FILTER_OFF, 16'h02}, {CMD_FILTER_ON, 16'h06},
    {CMD_SUPPLY_OFF, 16'h04}, {CMD_SOFT_RESET, 16'h46}, {8'h55, 16'h07}};
  always #5 i_core_clk = ~i_core_clk;
  brsr_host_model u_host (.i_core_clk(i_core_clk), .i_rdata(rdat),
    .o_req(req));
  brsr_bank u_dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_addr(req.addr), .i_wdata(req.wdata), .i_wr(req.wr), .i_rd(req.rd),
    .o_rdata(rdat), .o_auto_baseline_correction_ref(ref_v), .o_force_cal_ref(cal_v),
    .o_comm_err(fl[0]), .o_filter_en(fl[2]), .o_supply_comp_en(fl[1]),
    .o_soft_reset(fl[6]), .o_auto_baseline_correction_clear(fl[5]), .o_save_cal(fl[4]),
    .o_corr_clear(fl[3]));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask : rchk
  task automatic end_of_test;
    $display("mismatches %0d of %0d checks", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (5) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    #1 chk(ref_v, 16'h0190);
    foreach (rows[k])
    begin
      u_host.wr(ADDR_COMMAND, rows[k][23:16]);
      #1 chk(flw, rows[k][15:0]);
    end
    rchk(ADDR_COMMAND, 8'h00);
    u_host.wr(ADDR_SCRATCH, 8'ha5);
    rchk(ADDR_SCRATCH, 8'ha5);
    chk(ref_v, 16'h0190);
    // status write clears the sticky flag so each clamp shows afresh
    u_host.wr(ADDR_STATUS, 8'h01);
    u_host.wr(ADDR_REF_LOW, 8'h00);
    #1 chk(flw, 16'h0007);
    rchk(ADDR_REF_LOW, 8'h5e);
    u_host.wr(ADDR_STATUS, 8'h01);
    u_host.wr(ADDR_REF_HIGH, 8'h06);
    #1 chk(flw, 16'h0007);
    chk(ref_v, 16'h05dc);
    u_host.wr(ADDR_STATUS, 8'h01);
    u_host.wr(ADDR_REF_LOW, 8'h00);
    #1 chk(ref_v, 16'h0500);
    chk(flw, 16'h0006);
    u_host.wr(ADDR_REF_HIGH, 8'h80);
    #1 chk(ref_v, 16'h015e);
    chk(cal_v, 16'h015e);
    rchk(8'h33, 8'h00);
    rchk(ADDR_STATUS, 8'h07);
    rchk(ADDR_REF_HIGH, 8'h01);
    // read data stands one cycle only, then falls back to zero
    @(posedge i_core_clk);
    #1 chk({8'h00, rdat}, 16'h0000);
    @(posedge i_core_clk);
    i_reset_n <= 1'b0;
    #1 chk(flw, 16'h0006);
    chk(ref_v, 16'h0190);
    @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    rchk(ADDR_SCRATCH, 8'h00);
    end_of_test();
  end
endmodule : brsr_bank_test

// >>> tb/brsr_host_model.sv
// host model issuing one-cycle register strobes
`timescale 1ns/1ps
module brsr_host_model
  import brsr_pkg::*;
(
  input  wire logic       i_core_clk, // clock
  input  wire logic [7:0] i_rdata,    // read data
  output brsr_bus_req_t   o_req       // bus request
);
  initial o_req = '0;
  // released lines show inverted values so stale data cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_req <= '{a, d, 1'b1, 1'b0};
    @(posedge i_core_clk);
    o_req <= '{~a, ~d, 1'b0, 1'b0};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    o_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_core_clk);
    o_req <= '{~a, 8'hff, 1'b0, 1'b0};
    #1 d = i_rdata;
  endtask : rd
endmodule : brsr_host_model

// >>> verilog/brsr_bank.sv
// baseline reference, scratch and command register bank
`timescale 1ns/1ps
module brsr_bank
  import brsr_pkg::*;
(
  input  wire logic              i_core_clk,       // core clock 100 MHz
  input  wire logic              i_reset_n,        // async reset, low
  input  wire logic [ADDR_W-1:0] i_addr,           // register address
  input  wire logic [DATA_W-1:0] i_wdata,          // write data
  input  wire logic              i_wr,             // write strobe
  input  wire logic              i_rd,             // read strobe
  output logic [DATA_W-1:0]      o_rdata,          // read data, next cycle
  output logic [REF_W-1:0]       o_auto_baseline_correction_ref,       // ref for baseline corr
  output logic [REF_W-1:0]       o_force_cal_ref,  // ref for forced cal
  output logic                   o_comm_err,       // sticky error flag
  output logic                   o_filter_en,      // reactive filter on
  output logic                   o_supply_comp_en, // supply comp on
  output logic                   o_soft_reset,     // soft reset pulse
  output logic                   o_auto_baseline_correction_clear,     // clear context pulse
  output logic                   o_save_cal,       // save offset pulse
  output logic                   o_corr_clear      // clear factor pulse
);

  brsr_bus_req_t           req;
  brsr_state_t             state_reg;
  brsr_state_t             state_next;
  brsr_cmd_t               cmd;
  logic                    ref_wr;
  logic                    cmd_wr;
  logic signed [REF_W-1:0] ref_cand;
  logic signed [REF_W-1:0] ref_lim;
  logic                    ref_oor;

  // one driver for the whole carrier keeps lint from splitting it
  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  assign ref_wr = req.wr &&
                  (req.addr == ADDR_REF_HIGH || req.addr == ADDR_REF_LOW);
  assign cmd_wr = req.wr && (req.addr == ADDR_COMMAND);

  // the written byte replaces its half, the other half keeps its value
  always_comb
  begin
    ref_cand = {state_reg.ref_high, state_reg.ref_low};
    if (req.addr == ADDR_REF_HIGH)
    begin
      ref_cand = {req.wdata, state_reg.ref_low};
    end
    else if (req.addr == ADDR_REF_LOW)
    begin
      ref_cand = {state_reg.ref_high, req.wdata};
    end
  end

  brsr_ref_clamp u_clamp (
    .i_value     (ref_cand),
    .o_value     (ref_lim),
    .o_out_range (ref_oor)
  );

  brsr_cmd_decode u_decode (
    .i_code  (req.wdata),
    .i_valid (cmd_wr),
    .o_cmd   (cmd)
  );

  always_comb
  begin
    state_next        = state_reg;
    state_next.pulses = cmd;
    state_next.rdata  = '0;

    if (ref_wr)
    begin
      // both bytes are rewritten so the pair always holds the clamped value
      state_next.ref_high = ref_lim[15:8];
      state_next.ref_low  = ref_lim[7:0];
    end

    if (req.wr && req.addr == ADDR_SCRATCH)
    begin
      state_next.scratch = req.wdata;
    end

    if (req.wr && req.addr == ADDR_STATUS &&
        req.wdata[STS_COMM_ERR_BIT])
    begin
      state_next.comm_err = 1'b0;
    end

    if (cmd.filter_off)
    begin
      state_next.filter_en = 1'b0;
    end
    if (cmd.filter_on)
    begin
      state_next.filter_en = 1'b1;
    end
    if (cmd.supply_off)
    begin
      state_next.supply_comp_en = 1'b0;
    end

    // soft reset restores bank defaults; error flag survives for software
    if (cmd.soft_reset)
    begin
      state_next.ref_high       = RST_REF_HIGH;
      state_next.ref_low        = RST_REF_LOW;
      state_next.scratch        = RST_SCRATCH;
      state_next.filter_en      = 1'b1;
      state_next.supply_comp_en = 1'b1;
    end

    // set after clear so a same-cycle event wins over the software clear
    if ((ref_wr && ref_oor) || cmd.invalid)
    begin
      state_next.comm_err = 1'b1;
    end

    if (req.rd)
    begin
      unique case (req.addr)
        ADDR_REF_HIGH: state_next.rdata = state_reg.ref_high;
        ADDR_REF_LOW:  state_next.rdata = state_reg.ref_low;
        ADDR_SCRATCH:  state_next.rdata = state_reg.scratch;
        ADDR_COMMAND:  state_next.rdata = CMD_READ_VALUE;
        ADDR_STATUS:
        begin
          state_next.rdata[STS_COMM_ERR_BIT] = state_reg.comm_err;
          state_next.rdata[STS_FILTER_BIT]   = state_reg.filter_en;
          state_next.rdata[STS_SUPPLY_BIT]   = state_reg.supply_comp_en;
        end
        default:       state_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_reg                <= '0;
      state_reg.ref_high       <= RST_REF_HIGH;
      state_reg.ref_low        <= RST_REF_LOW;
      state_reg.scratch        <= RST_SCRATCH;
      state_reg.filter_en      <= 1'b1;
      state_reg.supply_comp_en <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign o_rdata          = state_reg.rdata;
  assign o_auto_baseline_correction_ref       = {state_reg.ref_high, state_reg.ref_low};
  assign o_force_cal_ref  = {state_reg.ref_high, state_reg.ref_low};
  assign o_comm_err       = state_reg.comm_err;
  assign o_filter_en      = state_reg.filter_en;
  assign o_supply_comp_en = state_reg.supply_comp_en;
  assign o_soft_reset     = state_reg.pulses.soft_reset;
  assign o_auto_baseline_correction_clear     = state_reg.pulses.auto_baseline_correction_clear;
  assign o_save_cal       = state_reg.pulses.save_cal;
  assign o_corr_clear     = state_reg.pulses.corr_clear;

endmodule : brsr_bank

// >>> verilog/brsr_cmd_decode.sv
// decoder for command register codes
`timescale 1ns/1ps
module brsr_cmd_decode
  import brsr_pkg::*;
(
  input  wire logic [DATA_W-1:0] i_code,   // written command code
  input  wire logic              i_valid,  // a command write is taking place
  output brsr_cmd_t              o_cmd     // one-hot decoded command
);

  always_comb
  begin
    o_cmd = '0;
    if (i_valid)
    begin
      unique case (i_code)
        CMD_SOFT_RESET: o_cmd.soft_reset = 1'b1;
        CMD_AUTO_BASELINE_CORRECTION_CLEAR: o_cmd.auto_baseline_correction_clear = 1'b1;
        CMD_SUPPLY_OFF: o_cmd.supply_off = 1'b1;
        CMD_SAVE_CAL:   o_cmd.save_cal   = 1'b1;
        CMD_FILTER_OFF: o_cmd.filter_off = 1'b1;
        CMD_CORR_CLEAR: o_cmd.corr_clear = 1'b1;
        CMD_FILTER_ON:  o_cmd.filter_on  = 1'b1;
        default:        o_cmd.invalid    = 1'b1;
      endcase
    end
  end

endmodule : brsr_cmd_decode

// >>> verilog/brsr_pkg.sv
// constants and types for the baseline reference and soft reset bank
package brsr_pkg;

  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 8;
  localparam int          REF_W             = 16;

  localparam logic [7:0]  ADDR_STATUS       = 8'h20;
  localparam logic [7:0]  ADDR_REF_HIGH     = 8'h0d;
  localparam logic [7:0]  ADDR_REF_LOW      = 8'h0e;
  localparam logic [7:0]  ADDR_SCRATCH      = 8'h0f;
  localparam logic [7:0]  ADDR_COMMAND      = 8'h10;

  localparam logic [7:0]  RST_REF_HIGH      = 8'h01;
  localparam logic [7:0]  RST_REF_LOW       = 8'h90;
  localparam logic [7:0]  RST_SCRATCH       = 8'h00;
  localparam logic [7:0]  CMD_READ_VALUE    = 8'h00;

  localparam int          STS_COMM_ERR_BIT  = 0;
  localparam int          STS_FILTER_BIT    = 1;
  localparam int          STS_SUPPLY_BIT    = 2;

  localparam logic signed [15:0] REF_MIN_PPM = 16'sh015e;
  localparam logic signed [15:0] REF_MAX_PPM = 16'sh05dc;

  localparam logic [7:0]  CMD_SOFT_RESET    = 8'ha3;
  localparam logic [7:0]  CMD_AUTO_BASELINE_CORRECTION_CLEAR    = 8'hbc;
  localparam logic [7:0]  CMD_SUPPLY_OFF    = 8'hcd;
  localparam logic [7:0]  CMD_SAVE_CAL      = 8'hcf;
  localparam logic [7:0]  CMD_FILTER_OFF    = 8'hdf;
  localparam logic [7:0]  CMD_CORR_CLEAR    = 8'hfc;
  localparam logic [7:0]  CMD_FILTER_ON     = 8'hfe;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } brsr_bus_req_t;

  typedef struct packed {
    logic soft_reset;
    logic auto_baseline_correction_clear;
    logic supply_off;
    logic save_cal;
    logic filter_off;
    logic corr_clear;
    logic filter_on;
    logic invalid;
  } brsr_cmd_t;

  typedef struct packed {
    logic [7:0]  ref_high;
    logic [7:0]  ref_low;
    logic [7:0]  scratch;
    logic        comm_err;
    logic        filter_en;
    logic        supply_comp_en;
    brsr_cmd_t   pulses;
    logic [7:0]  rdata;
  } brsr_state_t;

endpackage : brsr_pkg

// >>> verilog/brsr_ref_clamp.sv
// range limiter for the signed baseline reference
`timescale 1ns/1ps
module brsr_ref_clamp
  import brsr_pkg::*;
(
  input  wire logic signed [REF_W-1:0] i_value,    // candidate reference
  output logic signed [REF_W-1:0]      o_value,    // limited reference
  output logic                         o_out_range // candidate was clamped
);

  always_comb
  begin
    o_value     = i_value;
    o_out_range = 1'b0;
    if (i_value < REF_MIN_PPM)
    begin
      o_value     = REF_MIN_PPM;
      o_out_range = 1'b1;
    end
    else if (i_value > REF_MAX_PPM)
    begin
      o_value     = REF_MAX_PPM;
      o_out_range = 1'b1;
    end
  end

endmodule : brsr_ref_clamp
